/* File: logic/rtcsf_pkg.sv */
package rtcsf_pkg;

  // ----------------------------------------------------------------
  // device register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] RTCSF_IDX_ADJUST = 4'h7;
  localparam logic [3:0] RTCSF_IDX_CTRL1  = 4'he;
  localparam logic [3:0] RTCSF_IDX_CTRL2  = 4'hf;

  // ----------------------------------------------------------------
  // control register 1 fields
  // ----------------------------------------------------------------
  localparam int RTCSF_C1_WEEKDAY_EN = 7;
  localparam int RTCSF_C1_DAILY_EN   = 6;
  localparam int RTCSF_C1_H24        = 5;
  localparam int RTCSF_C1_CLKDIS_B   = 4;
  localparam int RTCSF_C1_TEST       = 3;
  localparam int RTCSF_C1_MODE_HI    = 2;

  // ----------------------------------------------------------------
  // status/control register two fields
  // ----------------------------------------------------------------
  localparam int RTCSF_C2_VDSL      = 7;
  localparam int RTCSF_C2_DROOP     = 6;
  localparam int RTCSF_C2_OSC_RUN   = 5;
  localparam int RTCSF_C2_PON       = 4;
  localparam int RTCSF_C2_CLKDIS_A  = 3;
  localparam int RTCSF_C2_PERIODIC  = 2;
  localparam int RTCSF_C2_WEEKDAY   = 1;
  localparam int RTCSF_C2_DAILY     = 0;

  // ----------------------------------------------------------------
  // periodic output modes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] RTCSF_MODE_OFF   = 3'h0;
  localparam logic [2:0] RTCSF_MODE_LOW   = 3'h1;
  localparam logic [7:0] RTCSF_RST_REG    = 8'h00;

  // ----------------------------------------------------------------
  // controller wishbone map
  // ----------------------------------------------------------------
  localparam logic [3:0] RTCSF_WB_CMD    = 4'h0;
  localparam logic [3:0] RTCSF_WB_STATUS = 4'h4;
  localparam int RTCSF_CMD_WDATA_LO = 8;
  localparam int RTCSF_CMD_WE       = 16;
  localparam int RTCSF_CMD_GO       = 31;
  localparam int RTCSF_ST_BUSY      = 8;
  localparam int RTCSF_ST_IRQA      = 9;
  localparam int RTCSF_ST_IRQB      = 10;

endpackage : rtcsf_pkg

/* File: logic/rtcsf_link_if.sv */
`timescale 1ns/1ps
interface rtcsf_link_if;
  logic       req;
  logic       we;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  logic       irq_pin_a_o;
  logic       irq_pin_a_oe;
  logic       irq_pin_b_o;
  logic       irq_pin_b_oe;
  logic       irq_pin_a_n;
  logic       irq_pin_b_n;

  // open-drain wires with pull-up
  assign irq_pin_a_n = irq_pin_a_oe ? irq_pin_a_o : 1'b1;
  assign irq_pin_b_n = irq_pin_b_oe ? irq_pin_b_o : 1'b1;

  modport dev (
    input  req, we, addr, wdata,
    output ack, rdata, irq_pin_a_o, irq_pin_a_oe, irq_pin_b_o, irq_pin_b_oe
  );
  modport host (
    output req, we, addr, wdata,
    input  ack, rdata, irq_pin_a_n, irq_pin_b_n
  );
endinterface : rtcsf_link_if

/* File: logic/rtcsf_host.sv */
`timescale 1ns/1ps
module rtcsf_host
  import rtcsf_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  rtcsf_link_if.host       link
);

  logic [7:0] last_rdata;
  logic       busy;
  logic [1:0] irq_a_sync;
  logic [1:0] irq_b_sync;
  logic       wb_hit;
  logic       cmd_go;

  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // a command acts on the edge where the master samples ack high
  assign cmd_go = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i
                  & (wb_adr_i[3:0] == RTCSF_WB_CMD)
                  & wb_sel_i[3] & wb_dat_i[RTCSF_CMD_GO] & ~busy;

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h0000_0000;
      if (wb_hit && !wb_we_i && wb_adr_i[3:0] == RTCSF_WB_STATUS) begin
        wb_dat_o <= {21'h000000, irq_b_sync[1], irq_a_sync[1], busy,
                     last_rdata};
      end
    end
  end

  // ----------------------------------------------------------------
  // device access; software alone picks the data, so only clearing
  // values should be written to sticky flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy       <= 1'b0;
      link.req   <= 1'b0;
      link.we    <= 1'b0;
      link.addr  <= 4'h0;
      link.wdata <= 8'h00;
      last_rdata <= 8'h00;
    end else if (cmd_go) begin
      busy       <= 1'b1;
      link.req   <= 1'b1;
      link.we    <= wb_dat_i[RTCSF_CMD_WE];
      link.addr  <= wb_dat_i[3:0];
      link.wdata <= wb_dat_i[RTCSF_CMD_WDATA_LO +: 8];
    end else if (busy && link.ack) begin
      busy       <= 1'b0;
      link.req   <= 1'b0;
      last_rdata <= link.rdata;
    end
  end

  // ----------------------------------------------------------------
  // interrupt pins come from another chip
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_a_sync <= 2'h3;
      irq_b_sync <= 2'h3;
    end else begin
      irq_a_sync <= {irq_a_sync[0], link.irq_pin_a_n};
      irq_b_sync <= {irq_b_sync[0], link.irq_pin_b_n};
    end
  end

endmodule : rtcsf_host

/* File: logic/rtcsf_device.sv */
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
// Functional notes
// - droop event sets sticky droop flag
// - writing zero clears droop flag, rearms
// - oscillator stop clears running flag
// - writing one arms stop detect; zero ignored
// - power-on reset sets power-on flag
// - zero clears power-on flag; one ignored
// - power-on flag forces other bits zero, except running flag
// - power-on reset releases both interrupt pins
// - both disables stop clock output
// - power-on reset clears both clock disables
// - disable bit is plain storage otherwise
// - periodic flag mirrors periodic pin drive
// - periodic clear only level mode, no daily
// - periodic flag sets again next tick
// - weekday alarm match sets flag if enabled
// - zero clears weekday flag, releases pin b
// - daily alarm match sets flag if enabled
// - daily clear releases pin a if idle
// - non-clearing writes leave flags unchanged
// - adjustment never touches clock output pin
// - pin a periodic or daily, b weekday
module rtcsf_device
  import rtcsf_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       power_on_reset_i,
  input  wire logic       supply_droop_i,
  input  wire logic       osc_stop_i,
  input  wire logic       periodic_tick_i,
  input  wire logic       periodic_wave_i,
  input  wire logic       weekday_match_i,
  input  wire logic       daily_match_i,
  input  wire logic       clkout_enable_input_i,
  input  wire logic       clk32_i,
  output logic            clock_output_pin_o,
  output logic [6:0]      rate_adjust_o,
  output logic            hour_24_o,
  output logic            droop_threshold_o,
  rtcsf_link_if.dev       link
);

  logic [7:0] ctrl1;
  logic       vdsl;
  logic       supply_droop_flag;
  logic       osc_running_flag;
  logic       power_on_detected_flag;
  logic       clkout_disable_a;
  logic       periodic_irq_flag;
  logic       weekday_alarm_flag;
  logic       daily_alarm_flag;
  logic [6:0] adjust;
  logic [1:0] foe_sync;
  logic [1:0] clk32_sync;
  logic       por;
  logic       wr_c1;
  logic       wr_c2;
  logic       wr_adj;
  logic       clr_droop;
  logic       clr_pon;
  logic       arm_osc;
  logic       clr_periodic;
  logic       clr_weekday;
  logic       clr_daily;
  logic       level_mode;
  logic [2:0] mode;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [3:0] idx);
    hit = link.req & link.we & ~link.ack & (link.addr == idx);
  endfunction : hit

  assign por        = rst_i | power_on_reset_i;
  assign wr_c1      = hit(RTCSF_IDX_CTRL1);
  assign wr_c2      = hit(RTCSF_IDX_CTRL2);
  assign wr_adj     = hit(RTCSF_IDX_ADJUST);
  assign mode       = ctrl1[RTCSF_C1_MODE_HI:0];
  assign level_mode = mode[2];
  // one decode per flag so a write clears each on its own
  assign clr_droop    = wr_c2 & ~link.wdata[RTCSF_C2_DROOP];
  assign clr_pon      = wr_c2 & ~link.wdata[RTCSF_C2_PON];
  assign arm_osc      = wr_c2 & link.wdata[RTCSF_C2_OSC_RUN];
  assign clr_periodic = wr_c2 & ~link.wdata[RTCSF_C2_PERIODIC];
  assign clr_weekday  = wr_c2 & ~link.wdata[RTCSF_C2_WEEKDAY];
  assign clr_daily    = wr_c2 & ~link.wdata[RTCSF_C2_DAILY];

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.ack   <= 1'b0;
      link.rdata <= 8'h00;
    end else begin
      link.ack <= link.req & ~link.ack;
      unique case (link.addr)
        RTCSF_IDX_ADJUST: link.rdata <= {1'b0, adjust};
        RTCSF_IDX_CTRL1:  link.rdata <= ctrl1;
        RTCSF_IDX_CTRL2:  link.rdata <= {vdsl, supply_droop_flag,
                                         osc_running_flag,
                                         power_on_detected_flag,
                                         clkout_disable_a, periodic_irq_flag,
                                         weekday_alarm_flag,
                                         daily_alarm_flag};
        default:          link.rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // power-on flag and oscillator flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (por) begin
      power_on_detected_flag <= 1'b1;
    end else if (clr_pon) begin
      power_on_detected_flag <= 1'b0;
    end
  end

  // stop event wins over a same-cycle arm; survives power-on forcing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_running_flag <= 1'b0;
    end else if (osc_stop_i) begin
      osc_running_flag <= 1'b0;
    end else if (arm_osc) begin
      osc_running_flag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // plain control bits, held at zero while power-on flag is up
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (por || power_on_detected_flag) begin
      ctrl1            <= RTCSF_RST_REG;
      vdsl             <= 1'b0;
      clkout_disable_a <= 1'b0;
      adjust           <= 7'h00;
    end else begin
      if (wr_c1) begin
        ctrl1 <= link.wdata;
      end
      if (wr_c2) begin
        vdsl             <= link.wdata[RTCSF_C2_VDSL];
        clkout_disable_a <= link.wdata[RTCSF_C2_CLKDIS_A];
      end
      if (wr_adj) begin
        adjust <= link.wdata[6:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky flags; a new event beats a same-cycle clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (por || power_on_detected_flag) begin
      supply_droop_flag <= 1'b0;
    end else if (supply_droop_i) begin
      supply_droop_flag <= 1'b1;
    end else if (clr_droop) begin
      supply_droop_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (por || power_on_detected_flag) begin
      weekday_alarm_flag <= 1'b0;
    end else if (!ctrl1[RTCSF_C1_WEEKDAY_EN]) begin
      weekday_alarm_flag <= 1'b0;
    end else if (weekday_match_i) begin
      weekday_alarm_flag <= 1'b1;
    end else if (clr_weekday) begin
      weekday_alarm_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (por || power_on_detected_flag) begin
      daily_alarm_flag <= 1'b0;
    end else if (!ctrl1[RTCSF_C1_DAILY_EN]) begin
      daily_alarm_flag <= 1'b0;
    end else if (daily_match_i) begin
      daily_alarm_flag <= 1'b1;
    end else if (clr_daily) begin
      daily_alarm_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // periodic output state; only level mode latches and can be cleared
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (por || power_on_detected_flag) begin
      periodic_irq_flag <= 1'b0;
    end else if (mode == RTCSF_MODE_OFF) begin
      periodic_irq_flag <= 1'b0;
    end else if (mode == RTCSF_MODE_LOW) begin
      periodic_irq_flag <= 1'b1;
    end else if (!level_mode) begin
      periodic_irq_flag <= periodic_wave_i;
    end else if (periodic_tick_i) begin
      periodic_irq_flag <= 1'b1;
    end else if (clr_periodic && !daily_alarm_flag) begin
      periodic_irq_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt pins, open drain, one cycle behind the flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (por) begin
      link.irq_pin_a_oe <= 1'b0;
      link.irq_pin_b_oe <= 1'b0;
    end else begin
      link.irq_pin_a_oe <= periodic_irq_flag | daily_alarm_flag;
      link.irq_pin_b_oe <= weekday_alarm_flag;
    end
  end

  always_ff @(posedge clk_i) begin
    link.irq_pin_a_o <= 1'b0;
    link.irq_pin_b_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // clock output; pins pass two flops first
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      foe_sync   <= 2'h0;
      clk32_sync <= 2'h0;
    end else begin
      foe_sync   <= {foe_sync[0], clkout_enable_input_i};
      clk32_sync <= {clk32_sync[0], clk32_i};
    end
  end

  // adjustment only leaves as rate_adjust_o, never gates this path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_output_pin_o <= 1'b0;
    end else begin
      clock_output_pin_o <= clk32_sync[1] & foe_sync[1]
                            & ~(clkout_disable_a
                                & ctrl1[RTCSF_C1_CLKDIS_B]);
    end
  end

  // ----------------------------------------------------------------
  // settings for the timekeeping logic
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_adjust_o     <= 7'h00;
      hour_24_o         <= 1'b0;
      droop_threshold_o <= 1'b0;
    end else begin
      rate_adjust_o     <= adjust;
      hour_24_o         <= ctrl1[RTCSF_C1_H24];
      droop_threshold_o <= vdsl;
    end
  end

endmodule : rtcsf_device

/* File: tb/rtcsf_asserts.sv */
`timescale 1ns/1ps
module rtcsf_asserts
  import rtcsf_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       req,
  input wire logic       we,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       irq_pin_a_o,
  input wire logic       irq_pin_a_oe,
  input wire logic       irq_pin_b_o,
  input wire logic       irq_pin_b_oe
);
  // ----------------------------------------
  // link handshake and pin relations
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_take;
    req && !ack;
  endsequence
  sequence s_rd_f;
    ack && !we && addr == RTCSF_IDX_CTRL2;
  endsequence
  sequence s_clr_b;
    s_take ##0 (we && addr == RTCSF_IDX_CTRL2 && !wdata[RTCSF_C2_WEEKDAY]);
  endsequence

  property p_answer;
    s_take |=> ack;
  endproperty
  a_answer: assert property (p_answer)
    else $error("link answer missing");
  property p_ack_pulse;
    ack |=> !ack && !req;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack or req stuck");
  property p_hold;
    s_take |=> $stable(addr) && $stable(we) && $stable(wdata);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request changed before ack");
  property p_rst_rel;
    $fell(rst_i) |-> !irq_pin_a_oe && !irq_pin_b_oe;
  endproperty
  a_rst_rel: assert property (p_rst_rel)
    else $error("irq pin driven after reset");
  property p_drive_low;
    (irq_pin_a_oe |-> !irq_pin_a_o) and (irq_pin_b_oe |-> !irq_pin_b_o);
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("irq pin driven high");
  property p_pon_force;
    s_rd_f ##0 rdata[RTCSF_C2_PON] |-> (rdata & 8'hcf) == 8'h00;
  endproperty
  a_pon_force: assert property (p_pon_force)
    else $error("bits set while power-on flag up");
  property p_pin_a;
    s_rd_f |-> irq_pin_a_oe == (rdata[2] | rdata[0]);
  endproperty
  a_pin_a: assert property (p_pin_a)
    else $error("pin a disagrees with flags");
  property p_pin_b;
    s_rd_f |-> irq_pin_b_oe == rdata[1];
  endproperty
  a_pin_b: assert property (p_pin_b)
    else $error("pin b disagrees with flag");
  property p_clr_b;
    s_clr_b |=> ##1 !irq_pin_b_oe;
  endproperty
  a_clr_b: assert property (p_clr_b)
    else $error("pin b not released");
endmodule : rtcsf_asserts

/* File: tb/rtc_status_flag_control_test.sv */
`timescale 1ns/1ps
module rtc_status_flag_control_test;
  import rtcsf_pkg::*;
  localparam logic [3:0] C1 = RTCSF_IDX_CTRL1;
  localparam logic [3:0] C2 = RTCSF_IDX_CTRL2;
  localparam logic [3:0] AJ = RTCSF_IDX_ADJUST;
  logic        clk, rst, cyc, stb, we, clkout_enable_input, c32, ack_o, pin, h24, thr, wav;
  logic [31:0] adr, dat, dat_o;
  logic [5:0]  ev;
  logic [6:0]  adj;
  int          mismatches, total_checks;

  rtcsf_link_if link();
  rtcsf_host u_rtcsf_host (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(4'hf), .wb_dat_o(dat_o), .wb_ack_o(ack_o), .link(link));
  rtcsf_device u_rtcsf_device (.clk_i(clk), .rst_i(rst),
    .power_on_reset_i(ev[5]), .supply_droop_i(ev[0]), .osc_stop_i(ev[1]),
    .periodic_tick_i(ev[2]), .periodic_wave_i(wav),
    .weekday_match_i(ev[3]), .daily_match_i(ev[4]),
    .clkout_enable_input_i(clkout_enable_input), .clk32_i(c32), .clock_output_pin_o(pin),
    .rate_adjust_o(adj), .hour_24_o(h24), .droop_threshold_o(thr),
    .link(link));
  rtcsf_asserts u_rtcsf_asserts (.clk_i(clk), .rst_i(rst), .req(link.req),
    .we(link.we), .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
    .rdata(link.rdata), .irq_pin_a_o(link.irq_pin_a_o),
    .irq_pin_a_oe(link.irq_pin_a_oe), .irq_pin_b_o(link.irq_pin_b_o),
    .irq_pin_b_oe(link.irq_pin_b_oe));

  // ----------------------------------------
  // reporting and bus tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic hang;
    mismatches++;
    $display("MISMATCH t=%0t wait timed out", $time);
    tally_and_finish();
  endtask : hang
  task automatic chk8(input logic [7:0] g, e, input string m);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, e, input string m);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, m, g, e);
    end
  endtask : chk1
  // always entered just after a rising edge; ack is sampled at the edge
  task automatic wb(input logic [3:0] a, input logic w,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {28'h0, a};
    dat <= d;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) hang();
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic dev(input logic [3:0] i, input logic w,
                     input logic [7:0] d, output logic [7:0] q);
    logic [31:0] s;
    int n;
    n = 0;
    wb(RTCSF_WB_CMD, 1'b1, {1'b1, 14'h0, w, d, 4'h0, i}, s);
    do begin
      wb(RTCSF_WB_STATUS, 1'b0, 32'h0, s);
      n++;
      if (n > 20) hang();
    end while (s[RTCSF_ST_BUSY] !== 1'b0);
    q = s[7:0];
  endtask : dev
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic [7:0] q;
    dev(i, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] i, input logic [7:0] e, string m);
    logic [7:0] q;
    dev(i, 1'b0, 8'h00, q);
    chk8(q, e, m);
  endtask : rd
  task automatic pins(input logic a, input logic b);
    logic [31:0] s;
    chk1(link.irq_pin_a_n, a, "pin a");
    chk1(link.irq_pin_b_n, b, "pin b");
    wb(RTCSF_WB_STATUS, 1'b0, 32'h0, s);
    chk1(s[RTCSF_ST_IRQA], a, "status pin a");
    chk1(s[RTCSF_ST_IRQB], b, "status pin b");
  endtask : pins
  // extra edges let the pin register follow the flag
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev <= 6'h00;
    repeat (3) @(posedge clk);
  endtask : pulse

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_power_up;
    logic [31:0] q;
    rd(C2, 8'h10, "ctrl2 after reset");
    pins(1'b1, 1'b1);
    wr(C1, 8'hff);
    wr(AJ, 8'h7f);
    rd(C1, 8'h00, "ctrl1 held");
    rd(AJ, 8'h00, "adjust held");
    wr(C2, 8'hef);
    rd(C2, 8'h20, "power-on cleared");
    rd(4'h3, 8'h00, "unknown index");
    wb(4'h8, 1'b0, 32'h0, q);
    chk1(q === 32'h0, 1'b1, "unmapped read");
  endtask : t_power_up
  task automatic t_droop_osc;
    pulse(0);
    rd(C2, 8'h60, "droop set");
    wr(C2, 8'h77);
    rd(C2, 8'h60, "ones ignored");
    wr(C2, 8'h37);
    rd(C2, 8'h20, "droop cleared alone");
    pulse(1);
    rd(C2, 8'h00, "osc stop seen");
    wr(C2, 8'h00);
    rd(C2, 8'h00, "zero to osc ignored");
    wr(C2, 8'h20);
    rd(C2, 8'h20, "osc rearmed");
  endtask : t_droop_osc
  task automatic t_alarms;
    wr(C1, 8'he0);
    chk1(h24, 1'b1, "24-hour out");
    pulse(3);
    pulse(4);
    rd(C2, 8'h23, "both alarms");
    pins(1'b0, 1'b0);
    wr(C2, 8'h21);
    rd(C2, 8'h21, "weekday cleared alone");
    pins(1'b0, 1'b1);
    wr(C2, 8'h22);
    rd(C2, 8'h20, "daily cleared");
    pins(1'b1, 1'b1);
    wr(C1, 8'h00);
    pulse(3);
    pulse(4);
    rd(C2, 8'h20, "disabled alarms");
    chk1(h24, 1'b0, "12-hour out");
  endtask : t_alarms
  task automatic t_periodic;
    wr(C1, 8'h04);
    pulse(2);
    rd(C2, 8'h24, "periodic set");
    wr(C2, 8'h20);
    pins(1'b1, 1'b1);
    pulse(2);
    rd(C2, 8'h24, "periodic again");
    wr(C1, 8'h44);
    pulse(4);
    wr(C2, 8'h21);
    rd(C2, 8'h25, "clear refused on daily");
    wr(C2, 8'h24);
    pins(1'b0, 1'b1);
    wr(C2, 8'h20);
    wr(C1, 8'h01);
    wr(C2, 8'h20);
    rd(C2, 8'h24, "fixed low not clearable");
    wr(C1, 8'h02);
    wav <= 1'b1;
    rd(C2, 8'h24, "pulse mode high");
    pins(1'b0, 1'b1);
    wav <= 1'b0;
    rd(C2, 8'h20, "pulse mode low");
    pins(1'b1, 1'b1);
    wr(C1, 8'h00);
    rd(C2, 8'h20, "periodic off");
  endtask : t_periodic
  task automatic t_clkout;
    clkout_enable_input <= 1'b1;
    c32 <= 1'b1;
    wr(AJ, 8'h7d);
    repeat (8) @(posedge clk);
    chk8({1'b0, adj}, 8'h7d, "adjust out");
    chk1(pin, 1'b1, "clock out high");
    c32 <= 1'b0;
    repeat (8) @(posedge clk);
    chk1(pin, 1'b0, "clock out low");
    c32 <= 1'b1;
    wr(C1, 8'h90);
    chk1(pin, 1'b1, "one disable only");
    wr(C2, 8'ha8);
    repeat (8) @(posedge clk);
    chk1(pin, 1'b0, "both disables");
    clkout_enable_input <= 1'b0;
    rd(C2, 8'ha8, "disable a stored");
    chk1(thr, 1'b1, "threshold out");
    pulse(3);
    pulse(5);
    pins(1'b1, 1'b1);
    rd(C1, 8'h00, "disable b reset");
    rd(C2, 8'h30, "disable a reset");
    chk1(thr, 1'b0, "threshold forced");
    chk8({1'b0, adj}, 8'h00, "adjust forced");
  endtask : t_clkout

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {cyc, stb, we, clkout_enable_input, c32, wav} = 6'h00;
    adr = 32'h0;
    dat = 32'h0;
    ev = 6'h00;
    mismatches = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_power_up();
    t_droop_osc();
    t_alarms();
    t_periodic();
    t_clkout();
    tally_and_finish();
  end
endmodule : rtc_status_flag_control_test
